//--- rtl/dsq_pkg.sv
// constants and types shared by the delta-sigma sequencer files
package dsq_pkg;
   // converter clock
   localparam int CLK_HZ = 250_000_000;
   // maximum output rate per resolution tier, samples per second
   localparam int RATE_20_SPS = 187;
   localparam int RATE_16_SPS = 48_000;
   localparam int RATE_12_SPS = 192_000;
   localparam int RATE_8_SPS = 384_000;
   // least conversion period in clock cycles, rounded up
   localparam int CYC_20 = (CLK_HZ + RATE_20_SPS - 1) / RATE_20_SPS;
   localparam int CYC_16 = (CLK_HZ + RATE_16_SPS - 1) / RATE_16_SPS;
   localparam int CYC_12 = (CLK_HZ + RATE_12_SPS - 1) / RATE_12_SPS;
   localparam int CYC_8 = (CLK_HZ + RATE_8_SPS - 1) / RATE_8_SPS;
   // widths
   localparam int RES_W = 5;
   localparam int CNT_W = 21;
   localparam int DAT_W = 24;
   localparam int PRIME_W = 3;
   // resolution thresholds
   localparam logic [RES_W-1:0] RES_8 = 5'h08;
   localparam logic [RES_W-1:0] RES_12 = 5'h0C;
   localparam logic [RES_W-1:0] RES_16 = 5'h10;
   localparam logic [RES_W-1:0] RES_TURBO_MIN = 5'h11;
   // samples in the decimator pipeline, and the single sample of turbo at high resolution
   localparam logic [PRIME_W-1:0] PRIME_FULL = 3'h4;
   localparam logic [PRIME_W-1:0] PRIME_ONE = 3'h1;
   localparam int HIST_N = 3;
   localparam int BUF_N = 2;

   typedef enum logic [1:0] {
      DSQ_MODE_SINGLE = 2'b00,
      DSQ_MODE_CONT = 2'b01,
      DSQ_MODE_MULTI = 2'b10,
      DSQ_MODE_TURBO = 2'b11
   } dsq_mode_t;

   typedef enum logic [1:0] {
      DSQ_ST_IDLE = 2'b00,
      DSQ_ST_RUN = 2'b01,
      DSQ_ST_WAIT = 2'b10
   } dsq_st_t;
endpackage

//--- rtl/dsq_strm_if.sv
// valid/ready word stream between sequencer and result buffer
interface dsq_strm_if;
   logic valid;
   logic ready;
   logic [dsq_pkg::DAT_W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

//--- rtl/dsq_buf.sv
// two-entry result buffer with valid and ready on both sides
module dsq_buf (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // streams
   dsq_strm_if.snk wr,
   dsq_strm_if.src rd
);
   typedef struct packed {
      logic [dsq_pkg::BUF_N-1:0][dsq_pkg::DAT_W-1:0] mem;
      logic wp;
      logic rp;
      logic [1:0] cnt;
   } dsq_buf_t;

   dsq_buf_t buf_r;
   dsq_buf_t buf_nxt;
   logic push;
   logic pop;

   assign wr.ready = (buf_r.cnt != 2'(dsq_pkg::BUF_N));
   assign rd.valid = (buf_r.cnt != 2'h0);
   assign rd.data = buf_r.mem[buf_r.rp];
   assign push = wr.valid && wr.ready;
   assign pop = rd.valid && rd.ready;

   always_comb begin
      buf_nxt = buf_r;
      if (push) begin
         buf_nxt.mem[buf_r.wp] = wr.data;
         buf_nxt.wp = ~buf_r.wp;
      end
      if (pop) begin
         buf_nxt.rp = ~buf_r.rp;
      end
      buf_nxt.cnt = buf_r.cnt + 2'(push) - 2'(pop);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         buf_r <= '0;
      end else begin
         buf_r <= buf_nxt;
      end
   end
endmodule // dsq_buf

//--- rtl/dsq_period.sv
// conversion period counter, one tick at each sample boundary
module dsq_period (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control
   input wire logic run,
   input wire logic restart,
   input wire logic [dsq_pkg::CNT_W-1:0] len,
   // boundary
   output logic tick
);
   typedef struct packed {
      logic [dsq_pkg::CNT_W-1:0] cnt;
   } dsq_per_t;

   dsq_per_t per_r;
   dsq_per_t per_nxt;

   assign tick = run && !restart && (per_r.cnt >= len - 1'b1);

   always_comb begin
      per_nxt = per_r;
      if (!run || restart || tick) begin
         per_nxt.cnt = '0;
      end else begin
         per_nxt.cnt = per_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         per_r <= '0;
      end else begin
         per_r <= per_nxt;
      end
   end
endmodule // dsq_period

//--- rtl/dsq_seq.sv
// delta-sigma converter sequencer: triggers, decimator priming, modes and done
// Summary of operation
// - result sums last four samples; reprime on input change
// - start bit or hardware trigger begins conversion
// - done and status stay high until result read
// - single mode: trigger, four conversions, done after fourth
// - single mode: after read, standby until next trigger
// - continuous: first result after priming, then every period
// - multi mode: reprime before each result, relaunch automatically
// - turbo: like multi to 16 bits, one-sample above
// - resolution selects period from maximum output rate
// - done rises one clock after the end of each conversion that completes the decimator priming, when the result enters the buffer
module dsq_seq #(
   parameter int CYC_16_P = dsq_pkg::CYC_16,
   parameter int CYC_20_P = dsq_pkg::CYC_20
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // configuration
   input wire logic [1:0] mode,
   input wire logic [dsq_pkg::RES_W-1:0] res_bits,
   // triggers and control
   input wire logic sw_start,
   input wire logic trig_in,
   input wire logic conv_stop,
   input wire logic sel_chg,
   // modulator bitstream
   input wire logic mod_bit,
   // result port
   output logic [dsq_pkg::DAT_W-1:0] res_data,
   output logic res_valid,
   input wire logic res_rd,
   // status
   output logic eoc_o,
   output logic eoc_stat,
   output logic busy,
   output logic overrun
);
   typedef struct packed {
      dsq_pkg::dsq_st_t st;
      logic trig_q;
      logic [dsq_pkg::PRIME_W-1:0] prime;
      logic [dsq_pkg::CNT_W-1:0] acc;
      logic [dsq_pkg::HIST_N-1:0][dsq_pkg::CNT_W-1:0] hist;
      logic [dsq_pkg::DAT_W-1:0] res;
      logic pend;
      logic ovr;
   } dsq_seq_t;

   // conversion period for a resolution, shortest allowed by its rate tier
   function automatic logic [dsq_pkg::CNT_W-1:0] period_len(
      input logic [dsq_pkg::RES_W-1:0] r);
      logic [dsq_pkg::CNT_W-1:0] len;
      len = dsq_pkg::CNT_W'(CYC_20_P);
      if (r <= dsq_pkg::RES_8) begin
         len = dsq_pkg::CNT_W'(dsq_pkg::CYC_8);
      end else if (r <= dsq_pkg::RES_12) begin
         len = dsq_pkg::CNT_W'(dsq_pkg::CYC_12);
      end else if (r <= dsq_pkg::RES_16) begin
         len = dsq_pkg::CNT_W'(CYC_16_P);
      end
      return len;
   endfunction

   dsq_seq_t seq_r;
   dsq_seq_t seq_nxt;
   logic start;
   logic restart;
   logic tick;
   logic [dsq_pkg::CNT_W-1:0] cur;
   logic [dsq_pkg::PRIME_W-1:0] need;
   logic [dsq_pkg::PRIME_W-1:0] prime_inc;
   logic [dsq_pkg::DAT_W-1:0] sum;
   logic turbo_hi;
   logic drained;

   dsq_strm_if to_buf ();
   dsq_strm_if from_buf ();

   dsq_period u_period (
      .clk(clk),
      .rst_b(rst_b),
      .run(seq_r.st == dsq_pkg::DSQ_ST_RUN),
      .restart(restart),
      .len(period_len(res_bits)),
      .tick(tick)
   );

   dsq_buf u_buf (
      .clk(clk),
      .rst_b(rst_b),
      .wr(to_buf),
      .rd(from_buf)
   );

   // a level trigger would retrigger forever, so only its rising edge counts
   assign start = sw_start || (trig_in && !seq_r.trig_q);
   assign restart = (seq_r.st == dsq_pkg::DSQ_ST_IDLE) && start;
   assign cur = seq_r.acc + dsq_pkg::CNT_W'(mod_bit);
   assign turbo_hi = (mode == dsq_pkg::DSQ_MODE_TURBO) && (res_bits >= dsq_pkg::RES_TURBO_MIN);
   assign need = turbo_hi ? dsq_pkg::PRIME_ONE : dsq_pkg::PRIME_FULL;
   assign prime_inc = (seq_r.prime >= need) ? seq_r.prime : seq_r.prime + 1'b1;
   assign sum = dsq_pkg::DAT_W'(cur) + dsq_pkg::DAT_W'(seq_r.hist[0])
      + dsq_pkg::DAT_W'(seq_r.hist[1]) + dsq_pkg::DAT_W'(seq_r.hist[2]);
   assign drained = !seq_r.pend && !from_buf.valid;

   assign to_buf.valid = seq_r.pend;
   assign to_buf.data = seq_r.res;
   assign from_buf.ready = res_rd;
   assign res_data = from_buf.data;
   assign res_valid = from_buf.valid;
   // done holds while an unread result sits in the buffer
   assign eoc_o = from_buf.valid;
   assign eoc_stat = from_buf.valid;
   assign busy = (seq_r.st != dsq_pkg::DSQ_ST_IDLE);
   assign overrun = seq_r.ovr;

   always_comb begin
      seq_nxt = seq_r;
      seq_nxt.trig_q = trig_in;
      if (to_buf.ready) begin
         seq_nxt.pend = 1'b0;
      end
      unique case (seq_r.st)
         dsq_pkg::DSQ_ST_IDLE: begin
            seq_nxt.prime = '0;
            seq_nxt.hist = '0;
            seq_nxt.acc = '0;
            if (start) begin
               seq_nxt.st = dsq_pkg::DSQ_ST_RUN;
               seq_nxt.ovr = 1'b0;
            end
         end
         dsq_pkg::DSQ_ST_RUN: begin
            seq_nxt.acc = cur;
            if (tick) begin
               seq_nxt.acc = '0;
               seq_nxt.hist[2] = seq_r.hist[1];
               seq_nxt.hist[1] = seq_r.hist[0];
               seq_nxt.hist[0] = cur;
               seq_nxt.prime = prime_inc;
               if (prime_inc >= need) begin
                  // new result; the set wins over the push of the old one
                  seq_nxt.res = sum;
                  seq_nxt.pend = 1'b1;
                  if (seq_r.pend && !to_buf.ready) begin
                     seq_nxt.ovr = 1'b1;
                  end
                  if (mode == dsq_pkg::DSQ_MODE_SINGLE) begin
                     seq_nxt.st = dsq_pkg::DSQ_ST_WAIT;
                  end else if (mode != dsq_pkg::DSQ_MODE_CONT) begin
                     seq_nxt.prime = '0;
                     seq_nxt.hist = '0;
                  end
               end
            end
            if (conv_stop) begin
               seq_nxt.st = dsq_pkg::DSQ_ST_IDLE;
            end
         end
         dsq_pkg::DSQ_ST_WAIT: begin
            if (drained || conv_stop) begin
               seq_nxt.st = dsq_pkg::DSQ_ST_IDLE;
            end
         end
         default: begin
            seq_nxt.st = dsq_pkg::DSQ_ST_IDLE;
         end
      endcase
      if (sel_chg) begin
         seq_nxt.prime = '0;
         seq_nxt.hist = '0;
         seq_nxt.acc = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seq_r <= '0;
      end else begin
         seq_r <= seq_nxt;
      end
   end
endmodule // dsq_seq

//--- sim/dsq_seq_assertions.sv
// port assertions for the delta-sigma sequencer
module dsq_seq_assertions #(
   parameter int CYC_16_P = 20,
   parameter int CYC_20_P = 40
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [1:0] mode,
   input wire logic [dsq_pkg::RES_W-1:0] res_bits,
   input wire logic sw_start,
   input wire logic trig_in,
   input wire logic conv_stop,
   input wire logic sel_chg,
   input wire logic res_valid,
   input wire logic res_rd,
   input wire logic eoc_o,
   input wire logic eoc_stat,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int D16 = 4 * CYC_16_P + 1;
   localparam int D20 = CYC_20_P + 1;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_go;
      !busy && sw_start && !conv_stop && !sel_chg && !res_valid;
   endsequence
   sequence s_first16;
      ##D16 !res_valid ##1 res_valid;
   endsequence
   sequence s_first20;
      ##D20 !res_valid ##1 res_valid;
   endsequence
   chk_done_lines: assert property (eoc_o == res_valid && eoc_stat == res_valid)
      else $error("done lines differ from valid");
   chk_done_holds: assert property (res_valid && !res_rd |=> res_valid)
      else $error("done dropped without read");
   chk_start_busy: assert property (!busy && sw_start && !conv_stop |=> busy)
      else $error("start bit not taken");
   chk_trig_edge: assert property (!busy && trig_in && !$past(trig_in) && !conv_stop |=> busy)
      else $error("trigger edge not taken");
   chk_four_prime: assert property (s_go and mode == 2'h0 && res_bits == 5'h10 |-> s_first16)
      else $error("single result not after four periods");
   chk_turbo_one: assert property (s_go and mode == 2'h3 && res_bits == 5'h14 |-> s_first20)
      else $error("turbo result not after one period");
   chk_back_idle: assert property ($fell(res_valid) && busy && mode == 2'h0 |-> ##[1:2] !busy)
      else $error("single mode stays busy after read");
   chk_idle_quiet: assert property (!busy && !$past(busy) && !res_valid && !sw_start
      && !(trig_in && !$past(trig_in)) |=> !res_valid)
      else $error("result appeared while idle");
endmodule // dsq_seq_assertions

//--- sim/dsq_reader.sv
// result reader standing for firmware or dma, with random stalls
module dsq_reader (
   // clock
   input wire logic clk,
   // result port
   input wire logic res_valid,
   output logic res_rd,
   // bench control: stop reading altogether
   input wire logic hold
);
   timeunit 1ns;
   timeprecision 1ps;
   initial res_rd = 1'b0;
   // reads only a word on offer, sometimes a few cycles late
   always @(negedge clk) res_rd <= res_valid && !hold && ($urandom % 3 != 0);
endmodule // dsq_reader

//--- sim/tb_top.sv
// self-checking testbench for the delta-sigma sequencer
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, sw_start, trig_in, conv_stop, sel_chg, mod_bit, draining, hold;
   logic res_valid, res_rd, eoc_o, eoc_stat, busy, overrun;
   logic [1:0] mode;
   logic [dsq_pkg::RES_W-1:0] res_bits;
   logic [dsq_pkg::DAT_W-1:0] res_data;
   logic [dsq_pkg::DAT_W-1:0] exp_q[$];
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int ress[4] = '{8, 12, 16, 20};
   int lens[4] = '{dsq_pkg::CYC_8, dsq_pkg::CYC_12, 20, 40};

   dsq_seq #(.CYC_16_P(20), .CYC_20_P(40)) i_dsq_seq (.clk(clk), .rst_b(rst_b), .mode(mode),
      .res_bits(res_bits), .sw_start(sw_start), .trig_in(trig_in), .conv_stop(conv_stop),
      .sel_chg(sel_chg), .mod_bit(mod_bit), .res_data(res_data), .res_valid(res_valid),
      .res_rd(res_rd), .eoc_o(eoc_o), .eoc_stat(eoc_stat), .busy(busy), .overrun(overrun));
   dsq_reader i_dsq_reader (.clk(clk), .res_valid(res_valid), .res_rd(res_rd), .hold(hold));

   task automatic check(input logic [23:0] seen, input logic [23:0] want);
      n_tests++;
      if (seen !== want) begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, seen, want);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // one run: expected words are queued as the start is given
   task automatic run(input logic [1:0] md, input int res, input logic mb, input int n,
      input int want, input bit hw);
      @(negedge clk);
      mode = md;
      res_bits = res[4:0];
      mod_bit = mb;
      @(negedge clk);
      if (hw) trig_in = 1'b1;
      else sw_start = 1'b1;
      repeat (n) exp_q.push_back(want[23:0]);
      @(negedge clk);
      sw_start = 1'b0;
      trig_in = 1'b0;
      while (exp_q.size() != 0) @(negedge clk);
      if (md == dsq_pkg::DSQ_MODE_SINGLE) begin
         repeat (3) @(negedge clk);
         check({23'h0, busy}, 24'h0);
      end else begin
         draining = 1'b1;
         conv_stop = 1'b1;
         @(negedge clk);
         conv_stop = 1'b0;
         repeat (200) @(negedge clk);
         draining = 1'b0;
      end
   endtask

   always @(posedge clk) begin
      if (rst_b && res_valid === 1'b1 && res_rd === 1'b1 && !draining) begin
         if (exp_q.size() == 0) begin
            err_count++;
            $display("[ERR] %0t extra result", $time);
         end else check(res_data, exp_q.pop_front());
      end
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         $display("[ERR] %0t timeout", $time);
         tally_and_finish();
      end
   end

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      {rst_b, sw_start, trig_in, conv_stop, sel_chg, mod_bit, draining, hold} = 8'h00;
      mode = 2'h0;
      res_bits = 5'h10;
      void'($urandom(77));
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      foreach (lens[k]) run(dsq_pkg::DSQ_MODE_SINGLE, ress[k], 1'b1, 1, 4 * lens[k], 1'b0);
      run(dsq_pkg::DSQ_MODE_SINGLE, 20, 1'b0, 1, 0, 1'b1);
      // input switched mid-conversion, bitstream zero after it: old samples must not count
      fork
         run(dsq_pkg::DSQ_MODE_SINGLE, 20, 1'b1, 1, 0, 1'b0);
         begin
            repeat (52) @(negedge clk);
            sel_chg = 1'b1;
            mod_bit = 1'b0;
            @(negedge clk);
            sel_chg = 1'b0;
         end
      join
      run(dsq_pkg::DSQ_MODE_MULTI, 16, 1'b1, 3, 80, 1'b0);
      run(dsq_pkg::DSQ_MODE_TURBO, 20, 1'b1, 3, 40, 1'b0);
      run(dsq_pkg::DSQ_MODE_TURBO, 16, 1'b1, 2, 80, 1'b0);
      // reader held: the fourth turbo result finds buffer and pending word full
      draining = 1'b1;
      hold = 1'b1;
      mode = dsq_pkg::DSQ_MODE_TURBO;
      res_bits = 5'h14;
      sw_start = 1'b1;
      @(negedge clk);
      sw_start = 1'b0;
      repeat (200) @(negedge clk);
      check({23'h0, overrun}, 24'h1);
      conv_stop = 1'b1;
      hold = 1'b0;
      @(negedge clk);
      conv_stop = 1'b0;
      repeat (200) @(negedge clk);
      draining = 1'b0;
      // one input held throughout the continuous run
      run(dsq_pkg::DSQ_MODE_CONT, 16, 1'b1, 4, 80, 1'b0);
      // a fresh start clears the lost-result flag
      check({23'h0, overrun}, 24'h0);
      tally_and_finish();
   end
endmodule // tb_top

bind dsq_seq dsq_seq_assertions #(.CYC_16_P(CYC_16_P), .CYC_20_P(CYC_20_P))
   i_dsq_seq_assertions (.clk(clk), .rst_b(rst_b), .mode(mode), .res_bits(res_bits),
   .sw_start(sw_start), .trig_in(trig_in), .conv_stop(conv_stop), .sel_chg(sel_chg),
   .res_valid(res_valid), .res_rd(res_rd), .eoc_o(eoc_o), .eoc_stat(eoc_stat), .busy(busy));
